// ---- boot_params.svh ----
`ifndef BOOT_PARAMS_SVH
`define BOOT_PARAMS_SVH

// ==========================================================
// Register map
// ==========================================================
`define ADDR_BOOT_CTRL    6'h3F
`define ADDR_HI_BIT       5
`define CMD_RW_BIT        7
`define CMD_ADDR_MSB      5

// ==========================================================
// Control register fields and reset values
// ==========================================================
`define CTRL_RAM_BIT      3
`define CTRL_LOAD_BIT     2
`define CTRL_RESET        8'h00
`define FW_REV_RESET      8'h00

// ==========================================================
// Signature register
// ==========================================================
`define SIG_SEED          8'h00
`define MISR_TAPS         8'h1D

// ==========================================================
// Program RAM and fill stream
// ==========================================================
`define RAM_DEPTH         4096
`define RAM_AW            12
`define FILL_CNT_W        13
`define FILL_LIMIT        13'h1000
`define FILL_W            20
`define BUF_DEPTH         2

`endif

// ---- boot_pkg.sv ----
package boot_pkg;

   // Serial transaction phases
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD  = 2'b01,
      PH_DATA = 2'b10,
      PH_DONE = 2'b11
   } phase_t;

endpackage : boot_pkg

// ---- host_mcu.sv ----
`timescale 1ns/10ps
// ======
// Host holding the image, serial port master
// ======
module host_mcu (
   // Port pins
   output logic       cs_n,
   output logic       sclk,
   output wire logic  data1_in,
   output logic       data2_in,
   input  wire logic  data1_out,
   input  wire logic  data1_oe,
   // Read result
   output logic [7:0] rd_byte,
   output logic       rd_seen
);
   logic d1_r;
   // Shared data pin: the device wins while it drives
   assign data1_in = data1_oe ? data1_out : d1_r;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      d1_r = 1'b0;
      data2_in = 1'b0;
      rd_byte = 8'h00;
      rd_seen = 1'b0;
   end
   // Command byte then data byte under one select; idle sclk picks order
   task automatic xfer(input logic lsb, input logic [15:0] frm, input int nbits);
      int j;
      #7;
      sclk = lsb;
      #100;
      cs_n = 1'b0;
      #100;
      for (int k = 0; k < nbits; k++) begin
         j = lsb ? k % 8 : 7 - k % 8;
         sclk = 1'b0;
         // Unused line toggles so it never looks stale
         d1_r = lsb ? frm[(k < 8 ? 8 : 0) + j] : ~d1_r;
         data2_in = lsb ? ~data2_in : frm[(k < 8 ? 8 : 0) + j];
         #100;
         if (k > 7) rd_byte[j] = data1_in;
         sclk = 1'b1;
         #100;
      end
      #100;
      sclk = lsb;
      #100;
      cs_n = 1'b1;
      d1_r = ~d1_r;
      #100;
      if (nbits == 16 && frm[15]) begin
         rd_seen = 1'b1;
         #1;
         rd_seen = 1'b0;
      end
   endtask : xfer
endmodule : host_mcu

// ---- program_ram.sv ----
`timescale 1ns/10ps
`include "boot_params.svh"
module program_ram
   import boot_pkg::*;
(
   // Clock
   input  wire logic                clk,
   // Fill write port
   input  wire logic                wr_en,
   input  wire logic [`RAM_AW-1:0]  wr_addr,
   input  wire logic [7:0]          wr_data,
   // Execution fetch port
   input  wire logic [`RAM_AW-1:0]  rd_addr,
   output logic      [7:0]          rd_data
);

   logic [7:0] mem_r [`RAM_DEPTH];

   // Contents are undefined until loaded; no reset on the array
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
   end

endmodule : program_ram

// ---- program_ram_bootloader.sv ----
`timescale 1ns/10ps
`include "boot_params.svh"
// ==========================================================
module program_ram_bootloader
   import boot_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Serial port pins
   input  wire logic                cs_n,
   input  wire logic                sclk,
   input  wire logic                data1_in,
   output logic                     data1_out,
   output logic                     data1_oe,
   input  wire logic                data2_in,
   // Device register access
   output logic      [5:0]          device_register_addr,
   output logic      [7:0]          device_register_wdata,
   output logic                     device_register_wr,
   output logic                     device_register_rd,
   input  wire logic [7:0]          device_register_rdata,
   // Program RAM write grant and fetch
   input  wire logic                ram_wr_ready,
   input  wire logic [`RAM_AW-1:0]  exec_addr,
   output logic      [7:0]          exec_data,
   // Firmware revision capture
   input  wire logic                fw_rev_load,
   input  wire logic [7:0]          fw_rev_value,
   output logic      [7:0]          firmware_revision,
   // Status
   output logic                     load_mode,
   output logic                     run_from_ram,
   output logic                     fill_overrun
);

   // ==========================================================
   // Functions
   // ==========================================================
   // One received bit into the shift register, in either bit order
   function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                           input logic       bit_in,
                                           input logic       lsb_first);
      shift_in = lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
   endfunction : shift_in

   // Bit reversal so the transmitter always shifts out of bit 7
   function automatic logic [7:0] reverse8(input logic [7:0] v);
      reverse8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction : reverse8

   // One MISR step folding in a data byte
   function automatic logic [7:0] misr_step(input logic [7:0] sig,
                                            input logic [7:0] din);
      misr_step = {sig[6:0], 1'b0} ^ (sig[7] ? `MISR_TAPS : 8'h00) ^ din;
   endfunction : misr_step

   // ==========================================================
   // Pin synchronisers and edge detection
   // ==========================================================
   logic [1:0] cs_sync_r;
   logic [1:0] sclk_sync_r;
   logic [1:0] d1_sync_r;
   logic [1:0] d2_sync_r;
   logic       cs_prev_r;
   logic       sclk_prev_r;

   // Two flops on every pin; only the second stage is looked at
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_sync_r   <= 2'h3;
         sclk_sync_r <= 2'h0;
         d1_sync_r   <= 2'h0;
         d2_sync_r   <= 2'h0;
         cs_prev_r   <= 1'b1;
         sclk_prev_r <= 1'b0;
      end else begin
         cs_sync_r   <= {cs_sync_r[0], cs_n};
         sclk_sync_r <= {sclk_sync_r[0], sclk};
         d1_sync_r   <= {d1_sync_r[0], data1_in};
         d2_sync_r   <= {d2_sync_r[0], data2_in};
         cs_prev_r   <= cs_sync_r[1];
         sclk_prev_r <= sclk_sync_r[1];
      end
   end

   logic cs_q;
   logic sclk_q;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;

   assign cs_q      = cs_sync_r[1];
   assign sclk_q    = sclk_sync_r[1];
   assign cs_fall   = ~cs_q & cs_prev_r;
   assign sclk_rise = sclk_q & ~sclk_prev_r & ~cs_q;
   assign sclk_fall = ~sclk_q & sclk_prev_r & ~cs_q;

   // ==========================================================
   // Transaction framing
   // ==========================================================
   phase_t     phase_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] cmd_r;
   logic       lsb_first_r;
   logic       rx_bit;
   logic [7:0] rx_byte;
   logic       last_bit;
   logic       cmd_done;
   logic       data_done;

   // Bidirectional LSB mode listens on data1, split MSB mode on data2
   assign rx_bit    = lsb_first_r ? d1_sync_r[1] : d2_sync_r[1];
   assign rx_byte   = shift_in(shift_r, rx_bit, lsb_first_r);
   assign last_bit  = sclk_rise & (bit_cnt_r == 3'h7);
   assign cmd_done  = last_bit & (phase_r == PH_CMD);
   assign data_done = last_bit & (phase_r == PH_DATA);

   // Select high always ends the transaction, whatever its progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r   <= PH_IDLE;
         bit_cnt_r <= 3'h0;
      end else if (cs_q) begin
         phase_r   <= PH_IDLE;
         bit_cnt_r <= 3'h0;
      end else begin
         case (phase_r)
            PH_IDLE: begin
               if (cs_fall) begin
                  phase_r   <= PH_CMD;
                  bit_cnt_r <= 3'h0;
               end
            end
            PH_CMD: begin
               if (sclk_rise) begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
               end
               if (cmd_done) begin
                  phase_r <= PH_DATA;
               end
            end
            PH_DATA: begin
               if (sclk_rise) begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
               end
               if (data_done) begin
                  phase_r <= PH_DONE;
               end
            end
            PH_DONE: begin
               phase_r <= PH_DONE;  // Extra clocks ignored until select rises
            end
            default: begin
               phase_r <= PH_IDLE;
            end
         endcase
      end
   end

   // Bit order latched at each select fall from the idle clock level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lsb_first_r <= 1'b0;
         shift_r     <= 8'h00;
         cmd_r       <= 8'h00;
      end else begin
         if (cs_fall) begin
            lsb_first_r <= sclk_q;
         end
         if (sclk_rise) begin
            shift_r <= rx_byte;
         end
         if (cmd_done) begin
            cmd_r <= rx_byte;
         end
      end
   end

   // ==========================================================
   // Command decode
   // ==========================================================
   logic       cmd_is_rd;
   logic       at_ctrl;
   logic       wr_done;
   logic       ctrl_wr;
   logic       fill_wr;
   logic       fill_take;
   logic       device_register_wr_w;
   logic [7:0] ctrl_r;
   logic       load_en;

   assign load_en   = ctrl_r[`CTRL_LOAD_BIT];
   assign cmd_is_rd = cmd_r[`CMD_RW_BIT];
   assign at_ctrl   = (cmd_r[`CMD_ADDR_MSB:0] == `ADDR_BOOT_CTRL);
   assign wr_done   = data_done & ~cmd_is_rd;
   assign ctrl_wr   = wr_done & at_ctrl;
   assign fill_wr   = wr_done & ~at_ctrl & load_en;
   assign device_register_wr_w = wr_done & ~at_ctrl & ~load_en;

   // ==========================================================
   // Control register and execution select
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= rx_byte;  // Reserved bits kept as written
      end
   end

   assign load_mode    = load_en;
   // Both load and RAM bits set still runs ROM: never execute a partial image
   assign run_from_ram = ctrl_r[`CTRL_RAM_BIT] & ~load_en;

   // ==========================================================
   // Fill address generator and signature
   // ==========================================================
   logic [`FILL_CNT_W-1:0] fill_cnt_r;
   logic [7:0]             sig_r;
   logic                   fill_full;

   assign fill_full = fill_cnt_r[`FILL_CNT_W-1];
   assign fill_take = fill_wr & ~fill_full;

   // Held at initial state whenever load mode is off; reads never step it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_cnt_r <= '0;
         sig_r      <= `SIG_SEED;
      end else if (!load_en) begin
         fill_cnt_r <= '0;
         sig_r      <= `SIG_SEED;
      end else if (fill_take) begin
         fill_cnt_r <= fill_cnt_r + 1'b1;
         sig_r      <= misr_step(sig_r, rx_byte);
      end
   end

   // ==========================================================
   // Fill staging into the two-entry buffer
   // ==========================================================
   logic                pend_valid_r;
   logic [`FILL_W-1:0]  pend_word_r;
   logic                buf_in_ready;
   logic                buf_out_valid;
   logic [`FILL_W-1:0]  buf_out_data;
   logic                overrun_r;

   // One byte waits here while the two-entry buffer is full;
   // a further fill arriving meanwhile cannot be held and is flagged.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_valid_r <= 1'b0;
         pend_word_r  <= '0;
         overrun_r    <= 1'b0;
      end else begin
         if (fill_take && (!pend_valid_r || buf_in_ready)) begin
            pend_valid_r <= 1'b1;
            pend_word_r  <= {fill_cnt_r[`RAM_AW-1:0], rx_byte};
         end else if (buf_in_ready) begin
            pend_valid_r <= 1'b0;
         end
         if (fill_take && pend_valid_r && !buf_in_ready) begin
            overrun_r <= 1'b1;
         end else if (!load_en) begin
            overrun_r <= 1'b0;
         end
      end
   end

   assign fill_overrun = overrun_r;

   two_entry_buffer #(
      .WIDTH (`FILL_W),
      .DEPTH (`BUF_DEPTH)
   ) two_entry_buffer_inst (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (pend_valid_r),
      .in_ready  (buf_in_ready),
      .in_data   (pend_word_r),
      .out_valid (buf_out_valid),
      .out_ready (ram_wr_ready),
      .out_data  (buf_out_data)
   );

   program_ram program_ram_inst (
      .clk     (clk),
      .wr_en   (buf_out_valid & ram_wr_ready),
      .wr_addr (buf_out_data[`FILL_W-1:8]),
      .wr_data (buf_out_data[7:0]),
      .rd_addr (exec_addr),
      .rd_data (exec_data)
   );

   // ==========================================================
   // Read path and transmitter
   // ==========================================================
   logic       rd_req_r;
   logic       rd_load_r;
   logic [7:0] rd_value;
   logic [7:0] tx_r;
   logic       oe_r;

   // Load-mode reads see only control or signature, never RAM
   assign rd_value = load_en ? (cmd_r[`ADDR_HI_BIT] ? ctrl_r : sig_r)
                             : (at_ctrl ? ctrl_r : device_register_rdata);

   // Device register read one cycle after the command byte lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_r  <= 1'b0;
         rd_load_r <= 1'b0;
      end else begin
         rd_req_r  <= cmd_done & rx_byte[`CMD_RW_BIT];
         rd_load_r <= rd_req_r;
      end
   end

   assign device_register_rd = rd_req_r & ~load_en & ~at_ctrl;

   // First data bit is presented before the first data-phase rising
   // edge; later bits change on falling edges once one bit has gone.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_r <= 8'h00;
         oe_r <= 1'b0;
      end else begin
         if (rd_load_r) begin
            tx_r <= lsb_first_r ? reverse8(rd_value) : rd_value;
         end else if (sclk_fall && phase_r == PH_DATA && bit_cnt_r != 3'h0) begin
            tx_r <= {tx_r[6:0], 1'b0};
         end
         if (cs_q) begin
            oe_r <= 1'b0;
         end else if (rd_load_r) begin
            oe_r <= 1'b1;
         end
      end
   end

   assign data1_out = tx_r[7];
   assign data1_oe  = oe_r;

   // ==========================================================
   // Device register write strobe and revision register
   // ==========================================================
   logic       device_register_wr_r;
   logic [7:0] wdata_r;
   logic [7:0] fw_rev_r;

   // Strobe one cycle after the last bit so address and data are settled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         device_register_wr_r <= 1'b0;
         wdata_r   <= 8'h00;
         fw_rev_r  <= `FW_REV_RESET;
      end else begin
         device_register_wr_r <= device_register_wr_w;
         if (data_done) begin
            wdata_r <= rx_byte;
         end
         if (fw_rev_load) begin
            fw_rev_r <= fw_rev_value;
         end
      end
   end

   assign device_register_wr           = device_register_wr_r;
   assign device_register_wdata        = wdata_r;
   assign device_register_addr         = cmd_r[`CMD_ADDR_MSB:0];
   assign firmware_revision = fw_rev_r;

endmodule : program_ram_bootloader

// ---- program_ram_bootloader_chk.sv ----
`timescale 1ns/10ps
`include "boot_params.svh"
// ======
// Port checks of the loader
// ======
module program_ram_bootloader_chk (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Pins and results
   input wire logic       cs_n,
   input wire logic       data1_oe,
   input wire logic [5:0] device_register_addr,
   input wire logic       device_register_wr,
   input wire logic       device_register_rd,
   input wire logic       fw_rev_load,
   input wire logic [7:0] fw_rev_value,
   input wire logic [7:0] firmware_revision,
   input wire logic       load_mode,
   input wire logic       run_from_ram,
   input wire logic       fill_overrun
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Control writes stay inside the loader
   chk_ctrl_private: assert property (device_register_wr |-> device_register_addr != `ADDR_BOOT_CTRL)
      else $error("control write leaked to device registers");
   chk_fill_quiet: assert property (device_register_wr |-> !load_mode)
      else $error("register strobe during load");
   chk_wr_single: assert property (device_register_wr |=> !device_register_wr)
      else $error("write strobe longer than one cycle");
   chk_rd_single: assert property ($rose(device_register_rd) |=> $fell(device_register_rd))
      else $error("read strobe longer than one cycle");
   chk_rd_load: assert property (device_register_rd |-> !load_mode)
      else $error("register read during load");
   // Pin driven only inside a frame; released once select stays high
   chk_oe_framed: assert property ($rose(data1_oe) |-> !cs_n)
      else $error("data pin driven without select");
   chk_oe_release: assert property (cs_n [*5] |-> !data1_oe)
      else $error("data pin still driven after select rose");
   chk_run_excl: assert property (run_from_ram |-> !load_mode)
      else $error("ram execution while loading");
   chk_ovr_clear: assert property (!load_mode [*3] |-> !fill_overrun)
      else $error("overrun kept outside load");
   chk_rev_take: assert property (fw_rev_load |=> firmware_revision == $past(fw_rev_value))
      else $error("revision not captured");
   // Control changes only at the end of a live frame
   chk_ctrl_frame: assert property ($changed(load_mode) |-> !$past(cs_n, 3))
      else $error("control changed outside a frame");
endmodule : program_ram_bootloader_chk

bind program_ram_bootloader program_ram_bootloader_chk program_ram_bootloader_chk_inst (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .data1_oe(data1_oe), .device_register_addr(device_register_addr),
   .device_register_wr(device_register_wr), .device_register_rd(device_register_rd), .fw_rev_load(fw_rev_load),
   .fw_rev_value(fw_rev_value), .firmware_revision(firmware_revision),
   .load_mode(load_mode), .run_from_ram(run_from_ram), .fill_overrun(fill_overrun));

// ---- program_ram_bootloader_tb.sv ----
`timescale 1ns/10ps
`include "boot_params.svh"
// ======
// Loader bench
// ======
module program_ram_bootloader_tb;
   logic              clk, rst_n, cs_n, sclk, data1_in, data1_out, data1_oe, data2_in;
   logic              device_register_wr, device_register_rd, ram_wr_ready, fw_rev_load, load_mode;
   logic              run_from_ram, fill_overrun, rd_seen;
   logic [5:0]        device_register_addr, a;
   logic [7:0]        device_register_wdata, device_register_rdata, exec_data, fw_rev_value, firmware_revision;
   logic [7:0]        rd_byte, sig, d, img[8];
   logic [`RAM_AW-1:0] exec_addr;
   logic [13:0]       exp_wr[$];
   logic [7:0]        exp_rd[$];
   logic [31:0]       seed = 32'h0000D727;
   int                err_total = 0;
   int                num_checks = 0;

   program_ram_bootloader program_ram_bootloader_inst (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .data1_in(data1_in),
      .data1_out(data1_out), .data1_oe(data1_oe), .data2_in(data2_in),
      .device_register_addr(device_register_addr), .device_register_wdata(device_register_wdata), .device_register_wr(device_register_wr), .device_register_rd(device_register_rd),
      .device_register_rdata(device_register_rdata), .ram_wr_ready(ram_wr_ready), .exec_addr(exec_addr),
      .exec_data(exec_data), .fw_rev_load(fw_rev_load), .fw_rev_value(fw_rev_value),
      .firmware_revision(firmware_revision), .load_mode(load_mode),
      .run_from_ram(run_from_ram), .fill_overrun(fill_overrun));
   host_mcu host_mcu_inst (.cs_n(cs_n), .sclk(sclk), .data1_in(data1_in), .data2_in(data2_in),
      .data1_out(data1_out), .data1_oe(data1_oe), .rd_byte(rd_byte), .rd_seen(rd_seen));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   function automatic logic [7:0] misr(input logic [7:0] s, input logic [7:0] v);
      return {s[6:0], 1'b0} ^ (s[7] ? `MISR_TAPS : 8'h00) ^ v;
   endfunction : misr
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %s exp %h seen %h", nm, want, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic lsb, input logic [5:0] ad, input logic [7:0] v);
      host_mcu_inst.xfer(lsb, {2'b00, ad, v}, 16);
   endtask : wr
   task automatic rd(input logic lsb, input logic [5:0] ad, input logic [7:0] e);
      exp_rd.push_back(e);
      host_mcu_inst.xfer(lsb, {2'b10, ad, 8'h00}, 16);
   endtask : rd
   task automatic ram_chk(input int n, input logic [7:0] e);
      @(posedge clk) exec_addr <= `RAM_AW'(n);
      @(posedge clk);
      @(negedge clk);
      check("ram byte", exec_data, e);
   endtask : ram_chk

   // Results matched oldest first against the driver's notes
   always @(posedge clk) if (device_register_wr !== 1'b0) check("reg write", {device_register_addr, device_register_wdata}, exp_wr.pop_front());
   always @(posedge rd_seen) check("read byte", rd_byte, exp_rd.pop_front());

   initial begin
      rst_n = 1'b0;
      device_register_rdata = 8'h00;
      ram_wr_ready = 1'b1;
      exec_addr = '0;
      fw_rev_load = 1'b0;
      fw_rev_value = 8'h00;
      sig = `SIG_SEED;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("status", {load_mode, run_from_ram, fill_overrun}, 3'b000);
      // Plain register traffic in both bit orders
      for (int m = 0; m < 2; m++) begin
         a = 6'(rnd() % 8'd63);
         d = rnd();
         exp_wr.push_back({a, d});
         wr(m[0], a, d);
         @(posedge clk) device_register_rdata <= rnd();
         @(posedge clk);
         rd(m[0], a, device_register_rdata);
      end
      // Frame cut after twelve bits must do nothing
      host_mcu_inst.xfer(1'b1, {2'b00, `ADDR_BOOT_CTRL, 8'h04}, 12);
      check("abort", load_mode, 1'b0);
      wr(1'b1, `ADDR_BOOT_CTRL, 8'h04);
      check("load on", load_mode, 1'b1);
      rd(1'b0, 6'h20, 8'h04);
      // RAM grant held off over three fills; reads and control writes mid-stream
      @(posedge clk) ram_wr_ready <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         img[i] = rnd();
         sig = misr(sig, img[i]);
         wr(i[0], 6'(rnd() % 8'd63), img[i]);
         if (i == 2) @(posedge clk) ram_wr_ready <= 1'b1;
         if (i == 4) begin
            rd(1'b1, 6'h1F, sig);
            wr(1'b0, `ADDR_BOOT_CTRL, 8'h04);
         end
      end
      rd(1'b1, 6'h00, sig);
      check("overrun", fill_overrun, 1'b0);
      for (int i = 0; i < 8; i++) ram_chk(i, img[i]);
      // Leaving load reseeds signature and fill address
      wr(1'b1, `ADDR_BOOT_CTRL, 8'h00);
      check("load off", load_mode, 1'b0);
      wr(1'b0, `ADDR_BOOT_CTRL, 8'h04);
      rd(1'b0, 6'h00, `SIG_SEED);
      d = rnd();
      wr(1'b1, 6'h11, d);
      rd(1'b1, 6'h00, misr(`SIG_SEED, d));
      ram_chk(0, d);
      wr(1'b0, `ADDR_BOOT_CTRL, 8'h08);
      check("ram run", {load_mode, run_from_ram}, 2'b01);
      rd(1'b1, `ADDR_BOOT_CTRL, 8'h08);
      wr(1'b1, `ADDR_BOOT_CTRL, 8'h0C);
      check("both set", run_from_ram, 1'b0);
      wr(1'b0, `ADDR_BOOT_CTRL, 8'h08);
      @(posedge clk) fw_rev_value <= rnd();
      fw_rev_load <= 1'b1;
      @(posedge clk) fw_rev_load <= 1'b0;
      @(negedge clk);
      check("revision", firmware_revision, fw_rev_value);
      // Hardware reset mid-run falls back to ROM
      @(posedge clk) rst_n <= 1'b0;
      @(negedge clk);
      check("hw reset", {run_from_ram, firmware_revision}, {1'b0, `FW_REV_RESET});
      @(posedge clk) rst_n <= 1'b1;
      rd(1'b0, `ADDR_BOOT_CTRL, `CTRL_RESET);
      final_report();
   end
   // About 30 frames of 4 us each, with ample slack
   initial begin
      #400000;
      err_total++;
      final_report();
   end
endmodule : program_ram_bootloader_tb

// ---- two_entry_buffer.sv ----
`timescale 1ns/10ps
module two_entry_buffer
   import boot_pkg::*;
#(
   parameter int WIDTH = 20,
   parameter int DEPTH = 2
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [PW:0]      count_r;
   logic             push;
   logic             pop;

   // Honest full and empty from the occupancy count
   assign in_ready  = (count_r != (PW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // Pointers wrap at DEPTH
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end

endmodule : two_entry_buffer
